/* File: src/watchdog_pkg.sv */
// Package with the watchdog control register layout, reset values and timebase constants.
package watchdog_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Control register placement and layout.
  localparam logic [7:0] CONTROL_ADDR = 8'hC0;
  localparam int PRESCALE_LSB = 4;
  localparam int IRQ_SEL_BIT = 3;
  localparam int STATUS_BIT = 2;
  localparam int ENABLE_BIT = 1;
  localparam int UNLOCK_BIT = 0;

  // Prescale codes with special meaning.
  localparam logic [3:0] PRESCALE_RESET = 4'h1;
  localparam logic [3:0] PRESCALE_MAX_TIMED = 4'h7;
  localparam logic [3:0] PRESCALE_IMMEDIATE = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // Crystal timebase: the period is two to the code times the base span.
  localparam int XTAL_HZ = 32768;
  localparam int BASE_TICKS_DEFAULT = 512;
  localparam int COUNT_W = 17;

  // Two reference periods in milliseconds and their crystal tick counts.
  localparam int TIMEOUT_MS_CODE6 = 1000;
  localparam int TIMEOUT_MS_CODE7 = 2000;
  localparam int TICKS_CODE6 = TIMEOUT_MS_CODE6 * XTAL_HZ / 1000;
  localparam int TICKS_CODE7 = TIMEOUT_MS_CODE7 * XTAL_HZ / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // Complete state of the block.
  typedef struct packed {
    logic [3:0] prescale;
    logic irq_sel;
    logic status;
    logic enable;
    logic unlock;
    logic [2:0] xtal_sync;
    logic [COUNT_W-1:0] count;
    logic reset_req;
    logic irq;
    logic [7:0] rdata;
  } wd_state_t;

  localparam wd_state_t STATE_RESET = '{prescale: PRESCALE_RESET, default: '0};

endpackage : watchdog_pkg

/* File: src/watchdog_control_logic.sv */
// Watchdog control logic with its control register on the processor's register bus.
`timescale 1ns/1ps
// Summary of operation
// - Four-bit prescale code selects timeout period; timeout gives a reset or an interrupt.
// - Code 8 resets immediately; codes above 8 are reserved and never time out.
// - Control bit 3 selects interrupt response; that interrupt is fixed high priority.
// - In interrupt mode the watchdog runs on as a periodic timer.
// - Status bit 2 is set on every watchdog timeout.
// - Status clears by writing zero or hardware reset; survives watchdog resets.
// - Writing enable bit 1 as one enables and restarts the timeout count.
// - Software must refresh the enable bit each period or the timeout fires.
// - Enable clears on write zero, reset response, hardware reset, supply-monitor interrupt.
// - Setting bit 0 unlocks; only the very next instruction may write the register.
// - Period is two to the code times 512 crystal periods, codes 0 to 7.
module watchdog_control_logic #(
  parameter int unsigned BASE_TICKS = watchdog_pkg::BASE_TICKS_DEFAULT
) (
  // System clock and hardware reset.
  input wire logic clock,
  input wire logic reset_n,
  // Crystal timebase pin.
  input wire logic xtal_clk,
  // Processor register bus.
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  input wire logic instr_end,
  output logic [7:0] sfr_rdata,
  // Supply monitor event.
  input wire logic supply_monitor_irq,
  // Timeout responses.
  output logic wd_reset_req,
  output logic wd_irq
);

  localparam int CW = watchdog_pkg::COUNT_W;

  ////////////////////////////////////////////////////////////////////////////
  // Last tick index of the period for a timed prescale code.
  function automatic logic [CW-1:0] last_tick(input logic [2:0] code);
    logic [CW-1:0] span;
    span = CW'(BASE_TICKS) << code;
    last_tick = span - CW'(1);
  endfunction : last_tick

  ////////////////////////////////////////////////////////////////////////////
  // State and decoded terms.
  watchdog_pkg::wd_state_t q;
  watchdog_pkg::wd_state_t d;
  logic tick;
  logic timed;
  logic at_limit;
  logic immediate;
  logic timeout;
  logic fire_reset;
  logic wr;
  logic accept;
  logic [3:0] wdata_prescale;

  // A rising crystal edge is seen only after two synchronising stages.
  // Stage 0 feeds only stage 1; stage 2 just remembers the last synchronised level.
  assign tick = q.xtal_sync[1] & ~q.xtal_sync[2];
  assign timed = q.prescale <= watchdog_pkg::PRESCALE_MAX_TIMED;
  assign immediate = q.prescale == watchdog_pkg::PRESCALE_IMMEDIATE;
  assign at_limit = q.count == last_tick(q.prescale[2:0]);
  // Missing refresh: the count reaches the end of its period, or code 8 fires at once.
  assign timeout = q.enable && ((timed && tick && at_limit) || immediate);
  // Code 8 always resets, whatever the response bit says.
  assign fire_reset = !q.irq_sel || immediate;
  assign wr = sfr_we && (sfr_addr == watchdog_pkg::CONTROL_ADDR);
  // Only a write that follows the unlock step changes the register.
  assign accept = wr && q.unlock;
  assign wdata_prescale = sfr_wdata[7:4];

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb
  begin
    d = q;
    d.xtal_sync = {q.xtal_sync[1:0], xtal_clk};
    d.reset_req = 1'b0;
    d.irq = 1'b0;

    // The count only advances on a timed code; reserved codes hold it still.
    if (q.enable && timed && tick)
    begin
      d.count = q.count + CW'(1);
    end

    // Two-step write protection.
    if (wr)
    begin
      if (q.unlock)
      begin
        d.prescale = sfr_wdata[7:4];
        d.irq_sel = sfr_wdata[watchdog_pkg::IRQ_SEL_BIT];
        d.enable = sfr_wdata[watchdog_pkg::ENABLE_BIT];
        if (!sfr_wdata[watchdog_pkg::STATUS_BIT])
        begin
          d.status = 1'b0;
        end
        if (sfr_wdata[watchdog_pkg::ENABLE_BIT])
        begin
          d.count = '0;
        end
        d.unlock = 1'b0;
      end
      else
      begin
        // A locked write only arms the unlock; every other bit is dropped.
        d.unlock = sfr_wdata[watchdog_pkg::UNLOCK_BIT];
      end
    end
    else if (instr_end && q.unlock)
    begin
      // The instruction after the unlock ended without a write.
      d.unlock = 1'b0;
    end

    // Timeout response; applied after the write so the status set wins.
    if (timeout)
    begin
      d.status = 1'b1;
      d.count = '0;
      if (fire_reset)
      begin
        d.reset_req = 1'b1;
        d.enable = 1'b0;
      end
      else
      begin
        d.irq = 1'b1;
      end
    end

    // A failing supply stops the watchdog so it cannot reset mid-recovery.
    if (supply_monitor_irq)
    begin
      d.enable = 1'b0;
    end

    // Reads return the current register; other addresses read zero.
    if (sfr_addr == watchdog_pkg::CONTROL_ADDR)
    begin
      d.rdata = {q.prescale, q.irq_sel, q.status, q.enable, q.unlock};
    end
    else
    begin
      d.rdata = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register. Only the hardware reset loads its reset values, so the status flag
  // survives the system reset that this block itself requests.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= watchdog_pkg::STATE_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state register.
  assign sfr_rdata = q.rdata;
  assign wd_reset_req = q.reset_req;
  assign wd_irq = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence s_arm;
    wr && !q.unlock && sfr_wdata[watchdog_pkg::UNLOCK_BIT];
  endsequence

  sequence s_skip;
    instr_end && !wr;
  endsequence

  sequence s_follow;
    wr;
  endsequence

  chk_code8_reset: assert property (
    (q.enable && immediate) |=> (wd_reset_req && !wd_irq && !q.enable))
    else $error("immediate code did not reset");

  chk_reserved_quiet: assert property (
    (q.enable && !timed && !immediate) |=> (!wd_reset_req && !wd_irq))
    else $error("reserved code produced a timeout");

  chk_irq_mode: assert property (
    wd_irq |-> ($past(q.irq_sel) && !$past(immediate)))
    else $error("interrupt without interrupt response");

  chk_period_end: assert property (
    (wd_irq || wd_reset_req) && $past(timed) |->
      $past(q.count) == last_tick($past(q.prescale[2:0])))
    else $error("timeout at wrong count");

  chk_periodic_run: assert property (
    (wd_irq && !$past(supply_monitor_irq) && !$past(accept)) |-> (q.enable && q.count == '0))
    else $error("interrupt mode did not restart");

  chk_status_set: assert property (
    (wd_irq || wd_reset_req) |-> q.status)
    else $error("status not set on timeout");

  chk_status_hold: assert property (
    ($past(q.status) && !$past(accept)) |-> q.status)
    else $error("status lost without a write");

  chk_enable_restart: assert property (
    (accept && sfr_wdata[watchdog_pkg::ENABLE_BIT] && !timeout && !supply_monitor_irq) |=>
      (q.enable && q.count == '0))
    else $error("enable write did not restart");

  chk_enable_clear: assert property (
    (wd_reset_req || $past(supply_monitor_irq)) |-> !q.enable)
    else $error("enable not cleared");

  chk_unlock_lapse: assert property (
    s_arm ##1 s_skip |=> !q.unlock)
    else $error("unlock outlived the next instruction");

  chk_unlock_accept: assert property (
    s_arm ##1 s_follow |=> q.prescale == $past(wdata_prescale))
    else $error("unlocked write not taken");

  chk_locked_ignored: assert property (
    (wr && !q.unlock) |=> $stable(q.prescale) && $stable(q.irq_sel))
    else $error("locked write changed the register");

  ////////////////////////////////////////////////////////////////////////////
  // Further checks on the response pulses, the count, the unlock and the written fields.
  sequence s_refused_write;
    wr && !q.unlock && !sfr_wdata[watchdog_pkg::UNLOCK_BIT];
  endsequence

  sequence s_quiet_tick;
    q.enable && timed && tick && !at_limit && !wr;
  endsequence

  // Each response is a single-cycle request, and never both at once.
  chk_reset_pulse: assert property (
    wd_reset_req |=> !wd_reset_req)
    else $error("reset request longer than one cycle");

  chk_irq_pulse: assert property (
    wd_irq |=> !wd_irq)
    else $error("interrupt request longer than one cycle");

  chk_one_response: assert property (
    !(wd_reset_req && wd_irq))
    else $error("both timeout responses at once");

  // The count moves one step per crystal tick and never while disabled.
  chk_count_step: assert property (
    s_quiet_tick |=> q.count == $past(q.count) + CW'(1))
    else $error("count missed a crystal tick");

  chk_count_idle: assert property (
    (!q.enable && !wr) |=> $stable(q.count))
    else $error("count moved while disabled");

  chk_count_wait: assert property (
    (q.enable && timed && !tick && !wr) |=> $stable(q.count))
    else $error("count moved without a crystal tick");

  // A refused write must not arm the lock, and an accepted one spends it.
  chk_refused_lock: assert property (
    s_refused_write |=> !q.unlock)
    else $error("refused write armed the unlock");

  chk_unlock_spent: assert property (
    s_arm ##1 s_follow |=> !q.unlock)
    else $error("unlock survived the accepted write");

  // Written fields land; a watchdog reset request never wipes the status.
  chk_enable_take: assert property (
    (accept && !sfr_wdata[watchdog_pkg::ENABLE_BIT]) |=> !q.enable)
    else $error("enable not cleared by a written zero");

  chk_status_clear: assert property (
    (accept && !sfr_wdata[watchdog_pkg::STATUS_BIT] && !timeout) |=> !q.status)
    else $error("status not cleared by a written zero");

  chk_status_survive: assert property (
    (wd_reset_req && !accept) |=> q.status)
    else $error("status lost after a watchdog reset request");

  chk_write_fields: assert property (
    accept |=> q.irq_sel == $past(sfr_wdata[watchdog_pkg::IRQ_SEL_BIT]))
    else $error("response select not taken from the write");

endmodule : watchdog_control_logic

/* File: testbench/cpu_core_model.sv */
// Behavioural processor core that drives the watchdog register bus.
`timescale 1ns/1ps
module cpu_core_model (
  // Clock.
  input wire logic clock,
  // Register bus.
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic sfr_we,
  output logic instr_end
);
  // The bus is idle at time zero.
  initial
  begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'hA5;
    sfr_we = 1'b0;
    instr_end = 1'b0;
  end
  ////////////////////////////////////////
  // One instruction cycle, launched at the falling edge. Outside writes the data
  // lines carry the inverse value, so stale data never looks valid.
  task cyc(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = we ? d : ~d;
    sfr_we = we;
    instr_end = we;
  endtask : cyc
  // Unlock, then write in the very next instruction with no interrupt between.
  task locked_wr(input logic [7:0] d);
    cyc(1'b1, watchdog_pkg::CONTROL_ADDR, 8'h01);
    cyc(1'b1, watchdog_pkg::CONTROL_ADDR, d);
    cyc(1'b0, 8'h00, 8'h00);
  endtask : locked_wr
  // Unlock, let one instruction end without a write, then try the write too late.
  task late_wr(input logic [7:0] d);
    cyc(1'b1, watchdog_pkg::CONTROL_ADDR, 8'h01);
    @(negedge clock);
    sfr_we = 1'b0;
    sfr_wdata = ~d;
    cyc(1'b1, watchdog_pkg::CONTROL_ADDR, d);
    cyc(1'b0, 8'h00, 8'h00);
  endtask : late_wr
endmodule : cpu_core_model

/* File: testbench/testbench.sv */
// Self-checking bench for the watchdog control logic.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("MISMATCH %s expected %h seen %h", nm, e, g); \
    end \
  end
module testbench;
  localparam logic [7:0] CA = watchdog_pkg::CONTROL_ADDR;
  logic clock;
  logic reset_n;
  logic xtal_clk;
  logic supply_monitor_irq;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic sfr_we;
  logic instr_end;
  logic [7:0] sfr_rdata;
  logic wd_reset_req;
  logic wd_irq;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  ////////////////////////////////////////
  // Small base span keeps each timeout to a few crystal ticks.
  watchdog_control_logic #(.BASE_TICKS(2)) i_dut (.clock(clock), .reset_n(reset_n),
    .xtal_clk(xtal_clk), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_we(sfr_we),
    .instr_end(instr_end), .sfr_rdata(sfr_rdata), .supply_monitor_irq(supply_monitor_irq),
    .wd_reset_req(wd_reset_req), .wd_irq(wd_irq));
  cpu_core_model i_core (.clock(clock), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_we(sfr_we), .instr_end(instr_end));
  // System clock at 20 MHz and crystal at 32.768 kHz, unrelated in phase.
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial
  begin
    xtal_clk = 1'b0;
    forever #15259 xtal_clk = ~xtal_clk;
  end
  ////////////////////////////////////////
  task end_sim;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // Readback is registered, so data is sampled one cycle after the address.
  task rd(input logic [7:0] a, input logic [7:0] e);
    i_core.cyc(1'b0, a, 8'h00);
    @(negedge clock);
    `CHK("readback", e, sfr_rdata)
  endtask : rd
  // Watch one response output for a bounded number of cycles.
  task wait_ev(input logic rq, input int lim, input logic e);
    logic seen;
    seen = 1'b0;
    repeat (lim)
    begin
      @(negedge clock);
      if ((rq ? wd_reset_req : wd_irq) === 1'b1)
        seen = 1'b1;
    end
    `CHK("event", e, seen)
  endtask : wait_ev
  task hw_reset;
    reset_n = 1'b0;
    repeat (16) @(negedge clock);
    reset_n = 1'b1;
  endtask : hw_reset
  // A hang counts as a mismatch.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      end_sim();
    end
  end
  ////////////////////////////////////////
  // Four-tick periods at code 1 fire between 1831 and 2447 cycles after a refresh.
  initial
  begin
    supply_monitor_irq = 1'b0;
    hw_reset();
    rd(CA, 8'h10);
    rd(8'hC1, 8'h00);
    i_core.late_wr(8'h62);
    rd(CA, 8'h10);
    i_core.cyc(1'b1, CA, 8'h62);
    rd(CA, 8'h10);
    i_core.locked_wr(8'h1A);
    rd(CA, 8'h1A);
    wait_ev(1'b0, 1800, 1'b0);
    wait_ev(1'b0, 700, 1'b1);
    rd(CA, 8'h1E);
    wait_ev(1'b0, 2600, 1'b1);
    i_core.locked_wr(8'h18);
    rd(CA, 8'h18);
    wait_ev(1'b0, 2600, 1'b0);
    i_core.locked_wr(8'h12);
    wait_ev(1'b1, 2600, 1'b1);
    rd(CA, 8'h14);
    i_core.locked_wr(8'h8E);
    wait_ev(1'b1, 4, 1'b1);
    rd(CA, 8'h8C);
    hw_reset();
    rd(CA, 8'h10);
    i_core.locked_wr(8'h92);
    wait_ev(1'b1, 2600, 1'b0);
    i_core.locked_wr(8'h1A);
    @(negedge clock);
    supply_monitor_irq = 1'b1;
    @(negedge clock);
    supply_monitor_irq = 1'b0;
    rd(CA, 8'h18);
    end_sim();
  end
endmodule : testbench
